/* File: core/scp_split_pwm.sv */
// Behaviour
// - Eight-bit duty, full cycle is 256 clocks
// - Sub-cycle rate clock/128 dual, clock/64 quad
// - Quad mode: four 64-clock sub-cycles 0..3
// - Quad mode: coarse bits 7..2, extra bits 1..0
// - Quad: sub-cycle below extra gets one more
// - Dual mode: two 128-clock sub-cycles 0..1
// - Dual mode: coarse bits 7..1, extra bit 0
// - Dual: sub-cycle below extra gets one more
// - One duty register per channel, duty/256
// - Splitting automatic; software sets duty, mode, enable
// - Waveform only when selected, output, data one
// - Selected output with data zero drives low
// - Direction one makes pin plain input
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module scp_split_pwm import scp_pkg::*; #(
	parameter int CH_COUNT = SCP_CHANNELS
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	// AXI4-Lite write address and data
	input  wire logic [SCP_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	// AXI4-Lite read
	input  wire logic [SCP_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// Shared pins
	input  wire logic [CH_COUNT-1:0]     pin_in,
	output logic      [CH_COUNT-1:0]     pin_out,
	output logic      [CH_COUNT-1:0]     pin_oe,
	output logic      [CH_COUNT-1:0]     pin_pull_en
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]          duty_register [CH_COUNT];
	logic [CH_COUNT-1:0] pwm_enable;
	logic [CH_COUNT-1:0] quad_mode;
	logic [CH_COUNT-1:0] port_direction;
	logic [CH_COUNT-1:0] port_output_data;
	logic [CH_COUNT-1:0] pull_high;
	scp_chan_type        active [CH_COUNT];
	logic [7:0]          cycle_cnt;
	logic [CH_COUNT-1:0] pwm_level;
	logic [CH_COUNT-1:0] next_level;
	logic                aw_held;
	logic                w_held;
	logic [SCP_ADDR_W-1:0] aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                do_write;
	logic [31:0]         next_rdata;
	logic                next_rerr;
	logic [31:0]         status;

	// ------------------------------------------------------------
	// Cycle counter and waveform
	// ------------------------------------------------------------

	// Free running; sub-cycle index and position are slices of it
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cycle_cnt <= 8'h00;
		end else begin
			cycle_cnt <= cycle_cnt + 8'h01;
		end
	end

	// Duty and mode are caught only at the cycle wrap, so software may
	// write them at any time without tearing a cycle in progress
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < CH_COUNT; i++) begin
				active[i] <= SCP_RST_CHAN;
			end
		end else if (cycle_cnt == SCP_CNT_LAST) begin
			for (int i = 0; i < CH_COUNT; i++) begin
				active[i].duty <= duty_register[i];
				active[i].quad <= quad_mode[i];
			end
		end
	end

	// Per-channel level from duty split into coarse and extra parts
	always_comb begin
		for (int i = 0; i < CH_COUNT; i++) begin
			next_level[i] = scp_level(active[i].duty, active[i].quad,
				cycle_cnt);
		end
	end

	// Level register feeds the status view; the pins register next_level themselves
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pwm_level <= '0;
		end else begin
			pwm_level <= next_level;
		end
	end

	// ------------------------------------------------------------
	// Pin control
	// ------------------------------------------------------------

	// Data bit gates the waveform; direction one releases the pin
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else begin
			for (int i = 0; i < CH_COUNT; i++) begin
				pin_oe[i] <= !port_direction[i];
				if (pwm_enable[i]) begin
					pin_out[i] <= port_output_data[i] && next_level[i];
				end else begin
					pin_out[i] <= port_output_data[i];
				end
			end
		end
	end

	// Pull-high stays under software control in either function
	assign pin_pull_en = pull_high;

	// ------------------------------------------------------------
	// AXI4-Lite write side
	// ------------------------------------------------------------

	// Address and data are taken in either order; no new one until
	// the response has gone, so at most one write is in flight
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Response; unmapped or read-only offsets answer SLVERR
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= SCP_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr[1:0] == 2'h0
				&& (aw_addr < SCP_OFS_DUTY0 + 8'(4 * CH_COUNT)
				|| (aw_addr >= SCP_OFS_ENABLE && aw_addr <= SCP_OFS_PULL)))
				? SCP_RESP_OKAY : SCP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register storage; all fields live in byte lane 0
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < CH_COUNT; i++) begin
				duty_register[i] <= SCP_RST_DUTY;
			end
			pwm_enable       <= CH_COUNT'(SCP_RST_ENABLE);
			quad_mode        <= CH_COUNT'(SCP_RST_MODE);
			port_direction   <= CH_COUNT'(SCP_RST_DIR);
			port_output_data <= CH_COUNT'(SCP_RST_DOUT);
			pull_high        <= CH_COUNT'(SCP_RST_PULL);
		end else if (do_write && w_strb[0]) begin
			for (int i = 0; i < CH_COUNT; i++) begin
				if (aw_addr == SCP_OFS_DUTY0 + 8'(4 * i)) begin
					duty_register[i] <= w_data[7:0];
				end
			end
			if (aw_addr == SCP_OFS_ENABLE) begin
				pwm_enable <= w_data[CH_COUNT-1:0];
			end else if (aw_addr == SCP_OFS_MODE) begin
				quad_mode <= w_data[CH_COUNT-1:0];
			end else if (aw_addr == SCP_OFS_DIR) begin
				port_direction <= w_data[CH_COUNT-1:0];
			end else if (aw_addr == SCP_OFS_DOUT) begin
				port_output_data <= w_data[CH_COUNT-1:0];
			end else if (aw_addr == SCP_OFS_PULL) begin
				pull_high <= w_data[CH_COUNT-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read side
	// ------------------------------------------------------------

	// Status shows the counter, live levels and pin inputs
	always_comb begin
		status = 32'h0000_0000;
		status[SCP_ST_CNT_LSB +: 8]        = cycle_cnt;
		status[SCP_ST_LVL_LSB +: CH_COUNT] = pwm_level;
		status[SCP_ST_PIN_LSB +: CH_COUNT] = pin_in;
	end

	// Address decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rerr  = 1'b0;
		if (s_axi_araddr == SCP_OFS_ENABLE) begin
			next_rdata[CH_COUNT-1:0] = pwm_enable;
		end else if (s_axi_araddr == SCP_OFS_MODE) begin
			next_rdata[CH_COUNT-1:0] = quad_mode;
		end else if (s_axi_araddr == SCP_OFS_DIR) begin
			next_rdata[CH_COUNT-1:0] = port_direction;
		end else if (s_axi_araddr == SCP_OFS_DOUT) begin
			next_rdata[CH_COUNT-1:0] = port_output_data;
		end else if (s_axi_araddr == SCP_OFS_PULL) begin
			next_rdata[CH_COUNT-1:0] = pull_high;
		end else if (s_axi_araddr == SCP_OFS_STATUS) begin
			next_rdata = status;
		end else begin
			next_rerr = 1'b1;
			for (int i = 0; i < CH_COUNT; i++) begin
				if (s_axi_araddr == SCP_OFS_DUTY0 + 8'(4 * i)) begin
					next_rdata[7:0] = duty_register[i];
					next_rerr       = 1'b0;
				end
			end
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	// One read in flight; data held until rready
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= SCP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rerr ? SCP_RESP_SLVERR : SCP_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Assertions and covers: channel 0, counter wrap, write response
	// ------------------------------------------------------------
	logic [8:0] high_sum;

	// Sum of levels over a full cycle, for the overall duty check
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			high_sum <= 9'h000;
		end else if (cycle_cnt == SCP_CNT_LAST) begin
			high_sum <= 9'h000;
		end else begin
			high_sum <= high_sum + {8'h00, next_level[0]};
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_CYCLE_WRAP: assert property (
		cycle_cnt == SCP_CNT_LAST |=> cycle_cnt == 8'h00)
		else $error("cycle counter did not wrap after 255");

	AST_OVERALL_DUTY: assert property (
		cycle_cnt == SCP_CNT_LAST |->
		high_sum + {8'h00, next_level[0]} == {1'b0, active[0].duty})
		else $error("high clocks per cycle differ from duty");

	AST_HOLD_DUTY: assert property (
		cycle_cnt != SCP_CNT_LAST |=> $stable(active[0]))
		else $error("active settings changed mid cycle");

	AST_QUAD_EXTRA: assert property (
		active[0].quad && cycle_cnt[5:0] == active[0].duty[7:2]
		&& active[0].duty[7:2] != 6'h00
		|=> pwm_level[0] ==
		($past(cycle_cnt[7:6]) < $past(active[0].duty[1:0])))
		else $error("quad extra clock wrong for sub-cycle");

	AST_DUAL_EXTRA: assert property (
		!active[0].quad && cycle_cnt[6:0] == active[0].duty[7:1]
		&& active[0].duty[7:1] != 7'h00
		|=> pwm_level[0] ==
		(!$past(cycle_cnt[7]) && $past(active[0].duty[0])))
		else $error("dual extra clock wrong for sub-cycle");

	AST_SUB_START: assert property (
		active[0].quad && cycle_cnt[5:0] == 6'h00
		&& active[0].duty[7:2] != 6'h00 |=> pwm_level[0])
		else $error("sub-cycle did not start high");

	AST_PIN_WAVE: assert property (
		pwm_enable[0] && !port_direction[0] && port_output_data[0]
		|=> pin_oe[0] && pin_out[0] == pwm_level[0])
		else $error("pin does not follow waveform");

	AST_PIN_LOW: assert property (
		pwm_enable[0] && !port_direction[0] && !port_output_data[0]
		|=> pin_oe[0] && !pin_out[0])
		else $error("gated pin not driven low");

	AST_PIN_INPUT: assert property (
		port_direction[0] |=> !pin_oe[0])
		else $error("input pin is driven");

	AST_WRITE_RESP: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write response late");

	COV_QUAD_EXTRA: cover property (
		active[0].quad && active[0].duty[1:0] == 2'h3
		&& cycle_cnt == SCP_CNT_LAST);
	COV_DUAL_EXTRA: cover property (
		!active[0].quad && active[0].duty[0] && cycle_cnt == SCP_CNT_LAST);
	COV_DUTY_UPDATE: cover property (
		cycle_cnt == SCP_CNT_LAST && duty_register[0] != active[0].duty);
	COV_PIN_WAVE: cover property (pin_oe[0] && pin_out[0] && pwm_enable[0]);

endmodule // scp_split_pwm

/* File: core/scp_pkg.sv */
package scp_pkg;

	// ------------------------------------------------------------
	// Channel and cycle geometry
	// ------------------------------------------------------------
	localparam int SCP_CHANNELS = 3;
	localparam int SCP_DUTY_W   = 8;
	localparam int SCP_CYCLE    = 256;  // clocks in one full cycle
	localparam int SCP_QUAD_SUB = 64;   // clocks per quad-split sub-cycle
	localparam int SCP_DUAL_SUB = 128;  // clocks per dual-split sub-cycle
	localparam logic [7:0] SCP_CNT_LAST = 8'(SCP_CYCLE - 1);

	// ------------------------------------------------------------
	// Register map, byte addresses
	// ------------------------------------------------------------
	localparam int SCP_ADDR_W = 8;
	localparam logic [7:0] SCP_OFS_DUTY0  = 8'h00; // duty_register n at +4n
	localparam logic [7:0] SCP_OFS_ENABLE = 8'h0C; // function select per ch
	localparam logic [7:0] SCP_OFS_MODE   = 8'h10; // 1 = quad, 0 = dual
	localparam logic [7:0] SCP_OFS_DIR    = 8'h14; // 1 = input
	localparam logic [7:0] SCP_OFS_DOUT   = 8'h18; // port output data
	localparam logic [7:0] SCP_OFS_PULL   = 8'h1C; // pull-high option
	localparam logic [7:0] SCP_OFS_STATUS = 8'h20; // read only

	// Reset values
	localparam logic [7:0] SCP_RST_DUTY   = 8'h00;
	localparam logic [2:0] SCP_RST_ENABLE = 3'h0;
	localparam logic [2:0] SCP_RST_MODE   = 3'h0;
	localparam logic [2:0] SCP_RST_DIR    = 3'h7;
	localparam logic [2:0] SCP_RST_DOUT   = 3'h0;
	localparam logic [2:0] SCP_RST_PULL   = 3'h0;

	// Status field positions
	localparam int SCP_ST_CNT_LSB = 0;  // [7:0] cycle counter
	localparam int SCP_ST_LVL_LSB = 8;  // [10:8] waveform levels
	localparam int SCP_ST_PIN_LSB = 12; // [14:12] pin input levels

	// AXI responses
	localparam logic [1:0] SCP_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SCP_RESP_SLVERR = 2'h2;

	// Settings a channel runs one whole cycle with
	typedef struct packed {
		logic       quad;
		logic [7:0] duty;
	} scp_chan_type;

	localparam scp_chan_type SCP_RST_CHAN = '{quad: 1'b0, duty: 8'h00};

	// Waveform level for a duty, mode and position in the full cycle
	function automatic logic scp_level(input logic [7:0] duty,
		input logic quad, input logic [7:0] cnt);
		logic [7:0] pos;
		logic [7:0] lim;
		pos = 8'h00;
		lim = 8'h00;
		if (quad) begin
			pos = {2'h0, cnt[5:0]};
			lim = {2'h0, duty[7:2]} + {7'h00, (cnt[7:6] < duty[1:0])};
		end else begin
			pos = {1'h0, cnt[6:0]};
			lim = {1'h0, duty[7:1]} + {7'h00, (!cnt[7] && duty[0])};
		end
		return pos < lim;
	endfunction

endpackage

/* File: bench/scp_pin_load.sv */
`timescale 1ns/10ps
module scp_pin_load import scp_pkg::*; #(
	parameter int CH_COUNT = SCP_CHANNELS
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                reset,
	// Pin side of the block
	input  wire logic [CH_COUNT-1:0] pin_out,
	input  wire logic [CH_COUNT-1:0] pin_oe,
	input  wire logic [CH_COUNT-1:0] pin_pull_en,
	// Level seen back at the pins
	output logic      [CH_COUNT-1:0] pin_in
);
	logic [CH_COUNT-1:0] float_level;

	// Floating lines flip each clock so no stale level can be trusted
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			float_level <= '0;
		end else begin
			float_level <= ~float_level;
		end
	end

	// Wire level: block drive first, then pull-high, else floating
	always_comb begin
		for (int i = 0; i < CH_COUNT; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (pin_pull_en[i]) begin
				pin_in[i] = 1'b1;
			end else begin
				pin_in[i] = float_level[i];
			end
		end
	end
endmodule // scp_pin_load

/* File: bench/testbench.sv */
`timescale 1ns/10ps
module testbench import scp_pkg::*; ;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        sys_clk, reset;
	logic [7:0]  awaddr, araddr, bc;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  pin_in, pin_out, pin_oe, pin_pull_en;
	logic [2:0]  en_sw, dir_sw, dout_sw, mode_sw, act_m;
	logic [7:0]  duty_sw [0:2];
	logic [7:0]  act_d [0:2];
	integer      miscompares, tests_run, i;
	// Rows: quad bits per channel, then duty of channels 0, 1, 2
	logic [26:0] rows [0:4] = '{{3'b111, 8'h00, 8'hFF, 8'h41},
		{3'b000, 8'h01, 8'hFE, 8'h80}, {3'b101, 8'h03, 8'h02, 8'h7F},
		{3'b111, 8'hB6, 8'h40, 8'h01}, {3'b010, 8'h3F, 8'hC1, 8'hFD}};
	logic [7:0]  ra [0:7] = '{SCP_OFS_DUTY0, 8'h04, 8'h08, SCP_OFS_ENABLE,
		SCP_OFS_MODE, SCP_OFS_DIR, SCP_OFS_DOUT, SCP_OFS_PULL};
	logic [7:0]  rv [0:7] = '{SCP_RST_DUTY, SCP_RST_DUTY, SCP_RST_DUTY,
		8'h00, 8'h00, {5'h00, SCP_RST_DIR}, 8'h00, 8'h00};

	scp_split_pwm dut (.sys_clk(sys_clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en));
	scp_pin_load load (.sys_clk(sys_clk), .reset(reset), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .pin_in(pin_in));

	// Clock; bench copy of the free-running 256-clock cycle counter
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk or posedge reset) begin
		bc <= reset ? 8'h00 : bc + 8'h01;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task results;
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// Both channels offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		logic ao, wo;
		ao = 1'b0;
		wo = 1'b0;
		@(posedge sys_clk);
		{awaddr, wdata, wstrb} <= {a, v, s};
		{awvalid, wvalid, bready} <= 3'b111;
		while (!(ao && wo)) begin
			@(posedge sys_clk);
			// Drop each valid by NBA so the edge that took it sees it high
			if (awvalid && awready) begin
				ao = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wo = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do @(posedge sys_clk); while (!(arvalid && arready));
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	// Write with full strobes, expect OKAY, track what software set
	task setr(input logic [7:0] a, input logic [7:0] v);
		wr(a, {24'h0, v}, 4'hF);
		cmp(r, SCP_RESP_OKAY);
		if (a < SCP_OFS_ENABLE) duty_sw[a[3:2]] = v;
		if (a == SCP_OFS_ENABLE) en_sw = v[2:0];
		if (a == SCP_OFS_MODE) mode_sw = v[2:0];
		if (a == SCP_OFS_DIR) dir_sw = v[2:0];
		if (a == SCP_OFS_DOUT) dout_sw = v[2:0];
	endtask
	function automatic logic lvl(logic [7:0] v, logic q, logic [7:0] p);
		if (q) return int'(p[5:0]) < int'(v[7:2]) + int'(p[7:6] < v[1:0]);
		return int'(p[6:0]) < int'(v[7:1]) + int'(!p[7] && v[0]);
	endfunction
	// Wait for a full-cycle boundary; duty and mode apply from there
	task sync;
		do @(negedge sys_clk); while (bc != 8'h00);
		act_d = duty_sw;
		act_m = mode_sw;
	endtask
	// Check every clock of the rest of the cycle on all pins
	task run_cycle;
		logic [7:0] p;
		logic e;
		do begin
			@(negedge sys_clk);
			p = bc - 8'h01;
			for (int c = 0; c < 3; c++) begin
				e = en_sw[c] ? dout_sw[c] & lvl(act_d[c], act_m[c], p)
					: dout_sw[c];
				cmp(pin_out[c], e);
				cmp(pin_oe[c], !dir_sw[c]);
			end
		end while (bc != 8'h00);
	endtask

	// Cut a hung run short
	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		results;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{miscompares, tests_run} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{en_sw, mode_sw, dout_sw, dir_sw} = {9'h0, 3'h7};
		duty_sw = '{8'h00, 8'h00, 8'h00};
		reset = 1'b1;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		for (i = 0; i < 8; i++) begin
			rd(ra[i]);
			cmp(d, {24'h0, rv[i]});
		end
		rd(8'h24);
		cmp({r, d}, {SCP_RESP_SLVERR, 32'h0});
		wr(SCP_OFS_STATUS, 32'h1, 4'hF);
		cmp(r, SCP_RESP_SLVERR);
		setr(SCP_OFS_ENABLE, 8'h07);
		setr(SCP_OFS_DIR, 8'h00);
		setr(SCP_OFS_DOUT, 8'h07);
		// Ordinary cases: every row over one whole checked cycle
		for (i = 0; i < 5; i++) begin
			setr(SCP_OFS_MODE, {5'h0, rows[i][26:24]});
			setr(8'h00, rows[i][23:16]);
			setr(8'h04, rows[i][15:8]);
			setr(8'h08, rows[i][7:0]);
			sync;
			run_cycle;
		end
		// Low strobe lane off: write answers OKAY and changes nothing
		wr(8'h00, 32'hFF, 4'hE);
		cmp(r, SCP_RESP_OKAY);
		rd(8'h00);
		cmp(d, 32'h3F);
		// New duty mid-cycle: old value to the end, new one after
		do @(negedge sys_clk); while (bc != 8'h40);
		setr(8'h00, 8'hC2);
		run_cycle;
		act_d = duty_sw;
		run_cycle;
		// Data zero forces low, input direction, function off
		setr(SCP_OFS_DOUT, 8'h06);
		setr(SCP_OFS_DIR, 8'h02);
		setr(SCP_OFS_PULL, 8'h02);
		setr(SCP_OFS_ENABLE, 8'h03);
		sync;
		run_cycle;
		cmp(pin_pull_en, 3'b010);
		rd(SCP_OFS_STATUS);
		cmp(d[SCP_ST_PIN_LSB+1], 1'b1);
		results;
	end
endmodule // testbench
